// [rtl/ocdt_regs.svh]
// Constants for the output compare unit with dedicated counter
`ifndef OCDT_REGS_SVH
`define OCDT_REGS_SVH
`define OCDT_CNT_W 16
`define OCDT_CNT_MAX 16'hFFFF
`define OCDT_CNT_ZERO 16'h0000
`define OCDT_SYNC_W 5
`define OCDT_SYNC_FREE 5'h00
`define OCDT_SYNC_SRCS 32
`define OCDT_CLK_SRCS 6
`define OCDT_CLK_SEL_W 3
`endif

// [rtl/ocdt_pkg.sv]
// Types for the output compare unit with dedicated counter
package ocdt_pkg;
    typedef enum logic [1:0]
    {
        OCDT_SINGLE = 2'h0,
        OCDT_CONT = 2'h1,
        OCDT_PWM = 2'h2,
        OCDT_OFF = 2'h3
    } ocdt_mode_t;

    typedef struct packed
    {
        logic [4:0] sync_source_select;
        logic trigger_mode_select;
        logic cascade_enable;
        logic [2:0] clk_sel;
        ocdt_mode_t mode;
    } ocdt_ctrl_t;

    typedef struct packed
    {
        logic [15:0] primary_compare_value;
        logic [15:0] secondary_compare_value;
    } ocdt_cmp_t;
endpackage

// [rtl/ocdt_sync2.sv]
// Two-stage synchroniser for a bus of pin-side levels
`timescale 1ns/1ps
module ocdt_sync2 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [rtl/ocdt_unit.sv]
// One output compare unit with its own 16-bit counter and cascade links
`timescale 1ns/1ps
`include "ocdt_regs.svh"

// How it works
// - Free-running counter wraps 0xFFFF to 0x0000
// - Counter matching either compare value gives event, except in off mode
// - Sync mode runs once clock source enabled
// - Sync mode clears counter on sync event
// - Trigger mode holds counter until sync event
// - Sync select zero or reset means free-running
// - Trigger bit picks trigger, else synchronous
// - Sync select chooses one of 31 sources
// - Each unit has own counter and compares
// - Odd/even pair forms 32-bit counter; only primary compare spans both halves
// - Odd unit low half, even unit high
// - Odd unit wrap increments even unit
// - Primary and secondary compare values provided
// - Single pulse, continuous pulses, or PWM output
// - Counter ticks from one of six clocks
module ocdt_unit (
    input wire logic sys_clk,
    input wire logic rst,
    input ocdt_pkg::ocdt_ctrl_t ctrl,
    input ocdt_pkg::ocdt_cmp_t cmp,
    input wire logic [5:0] clk_src,
    input wire logic [31:1] sync_src,
    input wire logic is_upper,
    input wire logic casc_carry_in,
    input wire logic casc_match_in,
    output logic casc_carry_out,
    output logic casc_match_out,
    output logic compare_out,
    output logic compare_event,
    output logic counter_running,
    output logic [15:0] compare_counter
);
    import ocdt_pkg::*;

    // --------------------------------------------------
    // Input synchronisation
    // --------------------------------------------------
    logic [5:0] clk_src_s;
    logic [31:1] sync_src_s;

    ocdt_sync2 #(.W(6)) u_clk_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(clk_src),
        .sync_out(clk_src_s)
    );

    ocdt_sync2 #(.W(31)) u_evt_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(sync_src),
        .sync_out(sync_src_s)
    );

    // --------------------------------------------------
    // Tick and sync event detection
    // --------------------------------------------------
    logic [5:0] clk_prev_q;
    logic [31:1] sync_prev_q;
    logic [31:0] sync_rise;
    logic src_rise;
    logic sync_evt;
    logic tick;
    logic free_mode;
    logic trig_mode;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_prev_q <= '0;
            sync_prev_q <= '0;
        end
        else
        begin
            clk_prev_q <= clk_src_s;
            sync_prev_q <= sync_src_s;
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi < `OCDT_SYNC_SRCS; gi++)
        begin : g_sync
            assign sync_rise[gi] = sync_src_s[gi] & ~sync_prev_q[gi];
        end
    endgenerate
    assign sync_rise[0] = 1'b0;

    always_comb
    begin
        src_rise = 1'b0;
        if (ctrl.clk_sel < 3'(`OCDT_CLK_SRCS))
        begin
            src_rise = clk_src_s[ctrl.clk_sel] & ~clk_prev_q[ctrl.clk_sel];
        end
    end

    assign sync_evt = sync_rise[ctrl.sync_source_select];
    assign free_mode = (ctrl.sync_source_select == `OCDT_SYNC_FREE);
    assign trig_mode = ~free_mode & ctrl.trigger_mode_select;
    // Upper unit of a pair steps only on the lower unit's wrap
    assign tick = (ctrl.cascade_enable & is_upper) ? casc_carry_in : src_rise;

    // --------------------------------------------------
    // Trigger arming
    // --------------------------------------------------
    logic armed_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            armed_q <= 1'b0;
        else if (!trig_mode)
            armed_q <= 1'b0;
        else if (sync_evt)
            armed_q <= 1'b1;
    end

    logic run;
    assign run = ~trig_mode | armed_q | sync_evt;

    // --------------------------------------------------
    // Counter
    // --------------------------------------------------
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic wrap;

    assign wrap = tick & run & (cnt_q == `OCDT_CNT_MAX);

    always_comb
    begin
        cnt_d = cnt_q;
        if (!free_mode && !trig_mode && sync_evt)
            cnt_d = `OCDT_CNT_ZERO;
        else if (tick && run)
            cnt_d = cnt_q + 16'h0001;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_q <= `OCDT_CNT_ZERO;
        else
            cnt_q <= cnt_d;
    end

    // --------------------------------------------------
    // Compare matching
    // --------------------------------------------------
    logic pri_hit;
    logic sec_hit;
    logic pri_match;
    logic sec_match;

    assign pri_hit = (cnt_q == cmp.primary_compare_value);
    assign sec_hit = (cnt_q == cmp.secondary_compare_value);
    // Upper unit's primary match needs its own hit and the lower half's registered match
    assign pri_match = (ctrl.cascade_enable && is_upper) ? (pri_hit & casc_match_in) : pri_hit;
    assign sec_match = sec_hit;

    logic edge_pri;
    logic edge_sec;
    logic pri_seen_q;
    logic sec_seen_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pri_seen_q <= 1'b0;
            sec_seen_q <= 1'b0;
        end
        else
        begin
            pri_seen_q <= pri_match;
            sec_seen_q <= sec_match;
        end
    end

    assign edge_pri = pri_match & ~pri_seen_q;
    assign edge_sec = sec_match & ~sec_seen_q;

    // --------------------------------------------------
    // Output waveform
    // --------------------------------------------------
    logic out_q;
    logic done_q;
    logic evt_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            out_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            case (ctrl.mode)
                OCDT_SINGLE:
                begin
                    if (edge_pri && !done_q)
                        out_q <= 1'b1;
                    else if (edge_sec && out_q)
                    begin
                        out_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
                OCDT_CONT:
                begin
                    done_q <= 1'b0;
                    if (edge_pri)
                        out_q <= 1'b1;
                    else if (edge_sec)
                        out_q <= 1'b0;
                end
                OCDT_PWM:
                begin
                    done_q <= 1'b0;
                    if (edge_pri)
                        out_q <= 1'b1;
                    else if (edge_sec)
                        out_q <= 1'b0;
                end
                default:
                begin
                    out_q <= 1'b0;
                    done_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            evt_q <= 1'b0;
        else
            evt_q <= (edge_pri | edge_sec) & (ctrl.mode != OCDT_OFF);
    end

    // Registered copies so every output leaves a flip-flop
    logic carry_q;
    logic run_q;
    logic low_match_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            carry_q <= 1'b0;
            run_q <= 1'b0;
            low_match_q <= 1'b0;
        end
        else
        begin
            carry_q <= wrap & ctrl.cascade_enable & ~is_upper;
            run_q <= run;
            // Lags one cycle, as the upper counter lags the lower
            low_match_q <= pri_hit;
        end
    end

    assign casc_carry_out = carry_q;
    assign casc_match_out = low_match_q;
    assign compare_out = out_q;
    assign compare_event = evt_q;
    assign counter_running = run_q;
    assign compare_counter = cnt_q;
endmodule

// [test/ocdt_src_model.sv]
// Model of on-chip clock and sync event sources
`timescale 1ns/1ps
module ocdt_src_model (
    input wire logic sys_clk,
    output logic [5:0] clk_src,
    output logic [31:1] sync_src
);
    initial
    begin
        clk_src = 6'h00;
        sync_src = '0;
    end
    // One rising edge, held past the input sampler
    task automatic fire(input bit sync, input int i);
        @(posedge sys_clk) #1;
        if (sync)
            sync_src[i] = 1'b1;
        else
            clk_src[i] = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        clk_src = 6'h00;
        sync_src = '0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
endmodule

// [test/ocdt_unit_assertions.sv]
// Assertions for the output compare unit
`timescale 1ns/1ps
module ocdt_unit_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input ocdt_pkg::ocdt_ctrl_t ctrl,
    input ocdt_pkg::ocdt_cmp_t cmp,
    input wire logic is_upper,
    input wire logic casc_carry_in,
    input wire logic compare_out,
    input wire logic compare_event,
    input wire logic counter_running,
    input wire logic [15:0] compare_counter
);
    import ocdt_pkg::*;
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_step;
        $changed(compare_counter) |-> compare_counter == $past(compare_counter) + 16'h0001
            || compare_counter == 16'h0000;
    endproperty
    a_step: assert property (p_step) else $error("counter jumped");
    property p_evt_cause;
        compare_event |-> $past(compare_counter) == $past(cmp.primary_compare_value)
            || $past(compare_counter) == $past(cmp.secondary_compare_value);
    endproperty
    a_evt_cause: assert property (p_evt_cause) else $error("event without match");
    property p_evt_pulse;
        compare_event |=> !compare_event;
    endproperty
    a_evt_pulse: assert property (p_evt_pulse) else $error("event too long");
    property p_off;
        (ctrl.mode == OCDT_OFF) [*2] |-> !compare_out && !compare_event;
    endproperty
    a_off: assert property (p_off) else $error("output while off");
    property p_pwm_rise;
        $rose(compare_out) && ctrl.mode == OCDT_PWM && $past(ctrl.mode) == OCDT_PWM
            |-> compare_event && $past(compare_counter) == $past(cmp.primary_compare_value);
    endproperty
    a_pwm_rise: assert property (p_pwm_rise) else $error("bad rise");
    property p_pwm_fall;
        $fell(compare_out) && ctrl.mode == OCDT_PWM && $past(ctrl.mode) == OCDT_PWM
            |-> compare_event && $past(compare_counter) == $past(cmp.secondary_compare_value);
    endproperty
    a_pwm_fall: assert property (p_pwm_fall) else $error("bad fall");
    property p_trig_hold;
        ctrl.trigger_mode_select && ctrl.sync_source_select != 5'h00 && !counter_running
            && !$past(counter_running) |-> $stable(compare_counter);
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("counter ran unarmed");
    property p_upper_inc;
        is_upper && ctrl.cascade_enable && casc_carry_in
            |=> compare_counter == $past(compare_counter) + 16'h0001;
    endproperty
    a_upper_inc: assert property (p_upper_inc) else $error("carry lost");
endmodule
bind ocdt_unit ocdt_unit_assertions u_chk (.sys_clk, .rst, .ctrl, .cmp, .is_upper, .casc_carry_in,
    .compare_out, .compare_event, .counter_running, .compare_counter);

// [test/ocdt_unit_test.sv]
// Self-checking bench for the output compare unit
`timescale 1ns/1ps
module ocdt_unit_test;
    import ocdt_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    ocdt_ctrl_t ctrl = '0;
    ocdt_cmp_t cmp = '0;
    logic is_upper = 1'b0;
    logic casc_carry_in = 1'b0;
    logic casc_match_in = 1'b0;
    logic [5:0] clk_src;
    logic [31:1] sync_src;
    logic compare_out, compare_event, counter_running;
    logic [15:0] compare_counter;
    logic casc_carry_out, casc_match_out;
    int n_evt = 0;
    int n_carry = 0;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    ocdt_unit DUT (.sys_clk, .rst, .ctrl, .cmp, .clk_src, .sync_src, .is_upper, .casc_carry_in,
        .casc_match_in, .casc_carry_out, .casc_match_out, .compare_out, .compare_event,
        .counter_running, .compare_counter);
    ocdt_src_model M (.sys_clk, .clk_src, .sync_src);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (compare_event === 1'b1)
            n_evt++;
        if (casc_carry_out === 1'b1)
            n_carry++;
        if (cyc == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        ctrl.mode = OCDT_PWM;
        cmp.primary_compare_value = 16'h0002;
        cmp.secondary_compare_value = 16'h0004;
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(compare_counter, 16'h0000, "reset");
        M.fire(0, 0);
        M.fire(0, 0);
        chk(compare_counter, 16'h0002, "free count");
        chk(compare_out, 1'b1, "pwm on");
        chk(casc_match_out, 1'b1, "low half match");
        M.fire(0, 0);
        M.fire(0, 0);
        chk(compare_out, 1'b0, "pwm off");
        chk(casc_match_out, 1'b0, "low half miss");
        chk(16'(n_evt), 16'h0002, "events");
        M.fire(0, 1);
        chk(compare_counter, 16'h0004, "unselected");
        for (int s = 0; s < 6; s++)
        begin
            ctrl.clk_sel = 3'(s);
            M.fire(0, s);
            chk(compare_counter, 16'(5 + s), "source");
        end
        ctrl.sync_source_select = 5'h03;
        M.fire(1, 4);
        chk(compare_counter, 16'h000A, "other sync");
        M.fire(1, 3);
        chk(compare_counter, 16'h0000, "sync clear");
        M.fire(0, 5);
        chk(compare_counter, 16'h0001, "sync run");
        ctrl.cascade_enable = 1'b1;
        is_upper = 1'b1;
        casc_carry_in = 1'b1;
        @(posedge sys_clk) #1;
        casc_carry_in = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(compare_counter, 16'h0002, "carry");
        chk(compare_out, 1'b0, "upper half only");
        casc_match_in = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(compare_out, 1'b1, "both halves");
        ctrl.cascade_enable = 1'b0;
        is_upper = 1'b0;
        ctrl.trigger_mode_select = 1'b1;
        ctrl.sync_source_select = 5'h1F;
        M.fire(0, 5);
        chk(compare_counter, 16'h0002, "held");
        chk(counter_running, 1'b0, "halted");
        M.fire(1, 31);
        chk(counter_running, 1'b1, "armed");
        ctrl.mode = OCDT_OFF;
        M.fire(0, 5);
        chk(compare_out, 1'b0, "off");
        ctrl.mode = OCDT_SINGLE;
        cmp.primary_compare_value = 16'h0004;
        cmp.secondary_compare_value = 16'h0005;
        M.fire(0, 5);
        chk(compare_out, 1'b1, "single on");
        M.fire(0, 5);
        cmp.primary_compare_value = 16'h0006;
        cmp.secondary_compare_value = 16'h0007;
        M.fire(0, 5);
        chk(compare_out, 1'b0, "single once");
        ctrl.mode = OCDT_CONT;
        cmp.primary_compare_value = 16'h0007;
        cmp.secondary_compare_value = 16'h0008;
        M.fire(0, 5);
        M.fire(0, 5);
        chk(compare_out, 1'b0, "cont off");
        cmp.primary_compare_value = 16'h0009;
        M.fire(0, 5);
        chk(compare_out, 1'b1, "cont again");
        chk(compare_counter, 16'h0009, "count");
        chk(16'(n_evt), 16'h0009, "all events");
        chk(16'(n_carry), 16'h0000, "no carry");
        end_sim();
    end
endmodule
